// File: rtl/gso_pkg.sv
// Package of constants and types for the gas sensor output-state logic.
package gso_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam longint CLK_HZ = 25000000;
  localparam int WARMUP_S = 45;
  localparam longint WARMUP_CYC = WARMUP_S * CLK_HZ;
  localparam int CYCLE_MHZ = 3300;
  localparam longint MEAS_CYC = (CLK_HZ * 1000) / CYCLE_MHZ;
  localparam int SETTLE_CYCLES = 4;
  localparam int CAL_PULL_MS = 100;
  localparam longint CAL_PULL_CYC = (CAL_PULL_MS * CLK_HZ) / 1000;
  localparam logic [15:0] BAUD_DIV_38400 = 16'h028B;
  localparam logic [15:0] BAUD_DIV_19200 = 16'h0516;
  localparam logic [15:0] BAUD_DIV_9600 = 16'h0A2C;
  localparam logic [15:0] BAUD_DIV_4800 = 16'h1458;
  localparam int UART_DATA_BITS = 8;
  localparam int UART_STOP_BITS = 1;
  // ************************************************************
  // Reading scale: signed, 1 LSB = 0.1 percent of full scale
  // ************************************************************
  localparam logic signed [15:0] READ_FAULT = -16'sd2500;
  localparam logic signed [15:0] READ_FS = 16'sh03E8;
  localparam logic [11:0] DAC_ZERO_V = 12'h000;
  localparam logic [11:0] DAC_WARM_V = 12'h0D0;
  localparam logic [11:0] DAC_FULL = 12'hFFF;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_IRQ_STAT = 4'h2;
  localparam logic [3:0] REG_IRQ_MASK = 4'h3;
  localparam logic [3:0] REG_READING = 4'h4;
  localparam logic [3:0] REG_ZERO_OFS = 4'h5;
  localparam logic [3:0] REG_SPAN_GAIN = 4'h6;
  localparam int CTRL_BAUD_LSB = 0;
  localparam int CTRL_OVR_LSB = 2;
  localparam int CTRL_FALLING = 4;
  localparam int CTRL_BRIDGE = 5;
  localparam int IRQ_W = 5;
  localparam int EV_WARM_DONE = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_FREEZE = 2;
  localparam int EV_ZERO = 3;
  localparam int EV_SPAN = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] GAIN_ONE = 16'h0100;

  typedef enum logic [1:0] {BAUD_38400, BAUD_19200, BAUD_9600, BAUD_4800} gso_baud_type;
  typedef enum logic [1:0] {OVR_100, OVR_125, OVR_150, OVR_200} gso_ovr_type;
  typedef enum {ST_WARM, ST_RUN, ST_FREEZE, ST_FAULT} gso_state_type;

  typedef struct packed {
    logic mem_bad;
    logic supply_bad;
    logic analog_bad;
  } gso_check_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } gso_bus_type;
endpackage : gso_pkg

// File: rtl/gso_uart_tx.sv
// Serial transmitter with 8 data bits, 1 stop bit, no parity.
`timescale 1ns/1ps
module gso_uart_tx import gso_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_div,
  input wire logic i_start,
  input wire logic [7:0] i_data,
  output logic o_busy,
  output logic o_txd
);
  logic [15:0] baud_cnt_r;
  logic [3:0] bit_cnt_r;
  logic [9:0] shift_r;
  wire tick = (baud_cnt_r == 16'h0000);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      baud_cnt_r <= 16'h0000;
      bit_cnt_r <= 4'h0;
      shift_r <= 10'h3FF;
      o_busy <= 1'b0;
      o_txd <= 1'b1;
    end else if (!o_busy) begin
      o_txd <= 1'b1;
      if (i_start) begin
        // Start bit low, eight data bits LSB first, one stop bit high.
        shift_r <= {1'b1, i_data, 1'b0};
        bit_cnt_r <= 4'(UART_DATA_BITS + UART_STOP_BITS + 1);
        baud_cnt_r <= 16'h0000;
        o_busy <= 1'b1;
      end
    end else if (tick) begin
      baud_cnt_r <= i_div - 16'h0001;
      if (bit_cnt_r == 4'h0) begin
        o_busy <= 1'b0;
        o_txd <= 1'b1;
      end else begin
        o_txd <= shift_r[0];
        shift_r <= {1'b1, shift_r[9:1]};
        bit_cnt_r <= bit_cnt_r - 4'h1;
      end
    end else begin
      baud_cnt_r <= baud_cnt_r - 16'h0001;
    end
  end
endmodule : gso_uart_tx

// File: rtl/gso_top.sv
// Output-state logic of the gas sensor: warm-up, clamp, fault, freeze, calibration.
// Behaviour
// - Serial frames carry eight data bits, one stop bit, no parity.
// - Baud rate selectable among 38400, 19200, 9600 and 4800.
// - Analog output held at start-up level for 45 s warm-up, then live.
// - Start-up level is zero-gas for bridge, 0.2 V for voltage variants.
// - Serial reading forced to minus 250 percent during warm-up.
// - Warm-up level and duration are parameters, not hard-wired.
// - Reading clamped at selected 100, 125, 150 or 200 percent over-range.
// - Memory, supply and analog checks run continuously, raising a fault.
// - Analog output is zero volts while a fault is present.
// - Serial reading is minus 250 percent while a fault is present.
// - Holding the serial receive pin low starts zero or span calibration.
// - Measurement cycle alternates source on and off at 3.3 Hz.
// - Transients freeze output at last value until settled.
// - A setting selects rising or falling analog output with gas level; the serial reading always rises.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module gso_top import gso_pkg::*; #(
  parameter longint WARMUP_CYCLES = WARMUP_CYC,
  parameter logic [11:0] WARMUP_LEVEL = DAC_WARM_V,
  parameter longint MEAS_CYCLES = MEAS_CYC,
  parameter longint CAL_CYCLES = CAL_PULL_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic signed [15:0] i_gas_raw,
  input wire logic i_gas_valid,
  input wire gso_check_type i_check,
  input wire logic i_transient,
  input wire logic i_rxd,
  output logic [15:0] o_rdata,
  output logic o_irq,
  output logic o_txd,
  output logic [11:0] o_dac,
  output logic o_source_on
);
  // Counters are 40 and 32 bits wide; larger counts would wrap without notice.
  if (WARMUP_CYCLES < 1 || MEAS_CYCLES < 2 || CAL_CYCLES < 1 ||
      WARMUP_CYCLES > 40'hFFFFFFFFFF || MEAS_CYCLES > 32'hFFFFFFFF ||
      CAL_CYCLES >= 32'hFFFFFFFF) begin : g_bad_counts
    $error("gso_top: counts out of range");
  end

  // ************************************************************
  // Registers and state
  // ************************************************************
  logic [7:0] ctrl_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic signed [15:0] zero_ofs_r;
  logic [15:0] span_gain_r;
  logic zero_done_r;
  gso_state_type state_r;
  gso_state_type state_nxt;
  logic [39:0] warm_cnt_r;
  logic [31:0] meas_cnt_r;
  logic [31:0] cal_cnt_r;
  logic [2:0] settle_r;
  logic signed [15:0] reading_r;
  logic [15:0] bus_rdata_nxt;
  logic tx_busy;
  logic tx_start_r;
  logic tx_hi_r;

  // ************************************************************
  // Decoding
  // ************************************************************
  function automatic logic signed [15:0] ovr_limit(input logic [1:0] sel);
    unique case (sel)
      2'd0: ovr_limit = READ_FS;
      2'd1: ovr_limit = 16'sd1250;
      2'd2: ovr_limit = 16'sd1500;
      2'd3: ovr_limit = 16'sd2000;
    endcase
  endfunction : ovr_limit

  wire [1:0] baud_sel = ctrl_r[CTRL_BAUD_LSB +: 2];
  wire [15:0] baud_div = (baud_sel == 2'd0) ? BAUD_DIV_38400 :
                         (baud_sel == 2'd1) ? BAUD_DIV_19200 :
                         (baud_sel == 2'd2) ? BAUD_DIV_9600 : BAUD_DIV_4800;
  wire fault = i_check.mem_bad | i_check.supply_bad | i_check.analog_bad;
  wire warm_done = (warm_cnt_r >= 40'(WARMUP_CYCLES));
  wire signed [31:0] corr_w = (32'(i_gas_raw) - 32'(zero_ofs_r)) * $signed({16'h0, span_gain_r});
  wire signed [15:0] corr = 16'(corr_w >>> 8);
  wire signed [15:0] limit = ovr_limit(ctrl_r[CTRL_OVR_LSB +: 2]);
  wire signed [15:0] clamped = (corr > limit) ? limit : corr;
  wire [11:0] dac_lin = (clamped <= 16'sd0) ? 12'h000 :
                        (clamped >= READ_FS) ? DAC_FULL : 12'((32'(clamped) * 4095) / 1000);
  wire [11:0] dac_live = ctrl_r[CTRL_FALLING] ? (DAC_FULL - dac_lin) : dac_lin;
  wire [11:0] warm_lvl = ctrl_r[CTRL_BRIDGE] ? (ctrl_r[CTRL_FALLING] ? DAC_FULL : DAC_ZERO_V)
                                             : WARMUP_LEVEL;
  wire cal_pull = ~i_rxd;
  wire cal_fire = cal_pull && (cal_cnt_r == 32'(CAL_CYCLES));
  wire cal_take = cal_fire && !fault && (state_r == ST_RUN);
  wire meas_end = (meas_cnt_r == 32'(MEAS_CYCLES - 1));
  wire wr_hit_stat = i_wr && (i_addr == REG_IRQ_STAT);
  wire [IRQ_W-1:0] irq_clr = wr_hit_stat ? i_wdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] ev;
  assign ev[EV_WARM_DONE] = (state_r == ST_WARM) && (state_nxt == ST_RUN);
  assign ev[EV_FAULT] = fault && (state_r != ST_FAULT);
  assign ev[EV_FREEZE] = i_transient && (state_r == ST_RUN);
  assign ev[EV_ZERO] = cal_take && !zero_done_r;
  assign ev[EV_SPAN] = cal_take && zero_done_r;
  // A new event in the clearing cycle keeps its bit set.
  wire [IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | ev;
  wire [IRQ_W-1:0] irq_mask_nxt = (i_wr && i_addr == REG_IRQ_MASK) ? i_wdata[IRQ_W-1:0]
                                                                    : irq_mask_r;
  // Low byte first, so the host rebuilds the word in arrival order.
  wire [7:0] tx_byte = tx_hi_r ? reading_r[7:0] : reading_r[15:8];

  // ************************************************************
  // Output state machine
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    if (fault) begin
      state_nxt = ST_FAULT;
    end else begin
      unique case (state_r)
        ST_WARM: if (warm_done) state_nxt = ST_RUN;
        ST_RUN: if (i_transient) state_nxt = ST_FREEZE;
        ST_FREEZE: if (!i_transient && settle_r == 3'(SETTLE_CYCLES)) state_nxt = ST_RUN;
        ST_FAULT: state_nxt = warm_done ? ST_RUN : ST_WARM;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_WARM;
      warm_cnt_r <= 40'h0;
      settle_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (!warm_done) warm_cnt_r <= warm_cnt_r + 40'h1;
      // Settling waits a few quiet cycles so one glitch-free sample does not release it.
      settle_r <= i_transient ? 3'h0 : (settle_r == 3'(SETTLE_CYCLES) ? settle_r : settle_r + 3'h1);
    end
  end

  // ************************************************************
  // Reading and analog output
  // ************************************************************
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      reading_r <= READ_FAULT;
      o_dac <= 12'h000;
    end else begin
      unique case (state_nxt)
        ST_FAULT: begin
          reading_r <= READ_FAULT;
          o_dac <= DAC_ZERO_V;
        end
        ST_WARM: begin
          reading_r <= READ_FAULT;
          o_dac <= warm_lvl;
        end
        ST_FREEZE: begin
          reading_r <= reading_r;
          o_dac <= o_dac;
        end
        ST_RUN: if (i_gas_valid) begin
          reading_r <= clamped;
          o_dac <= dac_live;
        end
      endcase
    end
  end

  // ************************************************************
  // Measurement cycle and manual calibration
  // ************************************************************
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      meas_cnt_r <= 32'h0;
      o_source_on <= 1'b1;
      cal_cnt_r <= 32'h0;
      zero_ofs_r <= 16'sh0000;
      span_gain_r <= GAIN_ONE;
      zero_done_r <= 1'b0;
    end else begin
      meas_cnt_r <= meas_end ? 32'h0 : meas_cnt_r + 32'h1;
      // Source is on for the first half of each 3.3 Hz period.
      o_source_on <= (meas_cnt_r < 32'(MEAS_CYCLES / 2)) ^ meas_end;
      // The pull counter saturates so one long press fires once.
      if (!cal_pull) cal_cnt_r <= 32'h0;
      else if (cal_cnt_r <= 32'(CAL_CYCLES)) cal_cnt_r <= cal_cnt_r + 32'h1;
      if (cal_take) begin
        if (!zero_done_r) begin
          zero_ofs_r <= i_gas_raw;
          zero_done_r <= 1'b1;
        end else if (corr > 16'sd0) begin
          span_gain_r <= 16'((32'(READ_FS) * 32'(span_gain_r)) / 32'(corr));
          zero_done_r <= 1'b0;
        end
      end
      if (i_wr && i_addr == REG_ZERO_OFS) zero_ofs_r <= i_wdata;
      if (i_wr && i_addr == REG_SPAN_GAIN) span_gain_r <= i_wdata;
    end
  end

  // ************************************************************
  // Register port and interrupt
  // ************************************************************
  always_comb begin
    unique case (i_addr)
      REG_CTRL: bus_rdata_nxt = {8'h00, ctrl_r};
      REG_STAT: bus_rdata_nxt = {11'h000, zero_done_r, i_transient, fault, warm_done,
                                 state_r == ST_FREEZE};
      REG_IRQ_STAT: bus_rdata_nxt = {11'h000, irq_stat_r};
      REG_IRQ_MASK: bus_rdata_nxt = {11'h000, irq_mask_r};
      REG_READING: bus_rdata_nxt = reading_r;
      REG_ZERO_OFS: bus_rdata_nxt = zero_ofs_r;
      REG_SPAN_GAIN: bus_rdata_nxt = span_gain_r;
      default: bus_rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= CTRL_RST;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      o_rdata <= 16'h0000;
      o_irq <= 1'b0;
    end else begin
      if (i_wr && i_addr == REG_CTRL) ctrl_r <= i_wdata[7:0];
      irq_mask_r <= irq_mask_nxt;
      irq_stat_r <= irq_stat_nxt;
      // Built from next values so the pin follows a mask or clear write on the same edge.
      o_irq <= |(irq_stat_nxt & irq_mask_nxt);
      o_rdata <= i_rd ? bus_rdata_nxt : 16'h0000;
    end
  end

  // ************************************************************
  // Serial reading transmitter: one reading per measurement cycle
  // ************************************************************
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_start_r <= 1'b0;
      tx_hi_r <= 1'b0;
    end else begin
      tx_start_r <= 1'b0;
      if (meas_end && !tx_busy) begin
        tx_start_r <= 1'b1;
        tx_hi_r <= 1'b1;
      end else if (tx_hi_r && !tx_busy && !tx_start_r) begin
        tx_start_r <= 1'b1;
        tx_hi_r <= 1'b0;
      end
    end
  end

  gso_uart_tx u_tx (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_div(baud_div),
    .i_start(tx_start_r),
    .i_data(tx_byte),
    .o_busy(tx_busy),
    .o_txd(o_txd)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  AST_FAULT_READ: assert property (@(posedge i_core_clk) disable iff (i_rst)
    fault |=> reading_r == READ_FAULT) else $error("reading not fault value");
  AST_FAULT_DAC: assert property (@(posedge i_core_clk) disable iff (i_rst)
    fault |=> o_dac == DAC_ZERO_V) else $error("dac not zero on fault");
  AST_WARM_READ: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_r == ST_WARM |-> reading_r == READ_FAULT) else $error("warm reading wrong");
  AST_CLAMP: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_r == ST_RUN |-> reading_r <= ovr_limit(ctrl_r[CTRL_OVR_LSB +: 2]) || $changed(ctrl_r))
    else $error("reading above clamp");
  AST_FREEZE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_r == ST_FREEZE && state_nxt == ST_FREEZE |=> $stable(reading_r))
    else $error("frozen reading moved");
  AST_PRIO: assert property (@(posedge i_core_clk) disable iff (i_rst)
    fault |=> state_r == ST_FAULT) else $error("fault lost priority");
  AST_WARM_END: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_r == ST_WARM && !warm_done |=> state_r != ST_RUN) else $error("warm-up ended early");
  AST_IRQ: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(o_irq) |-> $past(|(irq_stat_r | ev))) else $error("irq without status");
  AST_IRQ_LEVEL: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_irq == |(irq_stat_r & irq_mask_r)) else $error("irq level wrong");
  AST_WARM_DAC: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_nxt == ST_WARM |=> o_dac == $past(warm_lvl)) else $error("warm-up level not held");
  AST_SRC_PHASE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    meas_end |=> o_source_on) else $error("source not on at cycle start");
  sequence seq_zero_press;
    cal_take && !zero_done_r && !(i_wr && i_addr == REG_ZERO_OFS);
  endsequence
  sequence seq_span_locked;
    !zero_done_r && !(i_wr && i_addr == REG_SPAN_GAIN);
  endsequence
  AST_CAL_ZERO: assert property (@(posedge i_core_clk) disable iff (i_rst)
    seq_zero_press |=> zero_done_r && zero_ofs_r == $past(i_gas_raw))
    else $error("zero press not taken");
  AST_SPAN_ORDER: assert property (@(posedge i_core_clk) disable iff (i_rst)
    seq_span_locked |=> $stable(span_gain_r)) else $error("span taken without zero");
endmodule : gso_top

// File: test/gso_host_model.sv
// Host model: decodes the sensor's serial output and drives its receive pin.
`timescale 1ns/1ps
module gso_host_model (
  input wire logic i_core_clk,
  input wire logic [15:0] i_div,
  input wire logic i_txd,
  input wire logic i_pull,
  output logic o_rxd,
  output logic [15:0] o_word,
  output logic [7:0] o_count,
  output logic o_frame_err
);
  // ****************
  // Receiver
  // ****************
  logic [7:0] byte_r;
  // The pin idles high through the host pull-up; a press pulls it to ground.
  assign o_rxd = i_pull ? 1'b0 : 1'b1;
  initial begin
    o_word = 16'h0000;
    o_count = 8'h00;
    o_frame_err = 1'b0;
    forever begin
      @(negedge i_txd);
      repeat (i_div / 2) @(posedge i_core_clk);
      if (i_txd !== 1'b0) o_frame_err = 1'b1;
      for (int b = 0; b < 8; b++) begin
        repeat (i_div) @(posedge i_core_clk);
        byte_r[b] = i_txd;
      end
      repeat (i_div) @(posedge i_core_clk);
      if (i_txd !== 1'b1) o_frame_err = 1'b1;
      o_word = {byte_r, o_word[15:8]};
      o_count = o_count + 8'h01;
    end
  end
endmodule : gso_host_model

// File: test/gso_top_tb.sv
// Self-checking testbench for the gas sensor output-state logic.
`timescale 1ns/1ps
module gso_top_tb import gso_pkg::*;;
  // ****************
  // Bench
  // ****************
  localparam int WARM_N = 200;
  localparam logic [11:0] WARM_LVL = 12'h123;
  localparam int MEAS_N = 14000;
  localparam int CAL_N = 10;
  logic i_core_clk, i_rst, i_wr, i_rd, i_gas_valid, i_transient, pull;
  logic [3:0] i_addr;
  logic [15:0] i_wdata, o_rdata, rd_v, host_word;
  logic signed [15:0] i_gas_raw;
  gso_check_type i_check;
  logic o_irq, o_txd, o_source_on, rxd, frame_err;
  logic [11:0] o_dac;
  logic [7:0] host_count;
  int n_errors, checks, seed, z, v, k;
  gso_top #(.WARMUP_CYCLES(WARM_N), .WARMUP_LEVEL(WARM_LVL), .MEAS_CYCLES(MEAS_N),
    .CAL_CYCLES(CAL_N)) i_gso_top (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_gas_raw(i_gas_raw),
    .i_gas_valid(i_gas_valid), .i_check(i_check), .i_transient(i_transient), .i_rxd(rxd),
    .o_rdata(o_rdata), .o_irq(o_irq), .o_txd(o_txd), .o_dac(o_dac), .o_source_on(o_source_on));
  gso_host_model i_gso_host_model (.i_core_clk(i_core_clk), .i_div(BAUD_DIV_38400),
    .i_txd(o_txd), .i_pull(pull), .o_rxd(rxd), .o_word(host_word), .o_count(host_count),
    .o_frame_err(frame_err));
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp, input string name);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    chk(name, o_rdata, exp);
  endtask : rchk
  task automatic sample(input logic signed [15:0] val);
    @(posedge i_core_clk);
    i_gas_raw <= val;
    i_gas_valid <= 1'b1;
    @(posedge i_core_clk);
    i_gas_valid <= 1'b0;
    repeat (4) @(negedge i_core_clk);
  endtask : sample
  task automatic press();
    @(posedge i_core_clk);
    pull <= 1'b1;
    repeat (CAL_N + 2) @(posedge i_core_clk);
    pull <= 1'b0;
    repeat (4) @(posedge i_core_clk);
  endtask : press
  task automatic rise_wait(output int n);
    logic p;
    n = 0;
    do begin
      p = o_source_on;
      @(negedge i_core_clk);
      n++;
    end while (!(p === 1'b0 && o_source_on === 1'b1) && n < 2 * MEAS_N);
  endtask : rise_wait
  // Clamp limit per over-range code, in tenths of a percent.
  function automatic logic [15:0] lim(input int o);
    return o == 0 ? 16'h03E8 : o == 1 ? 16'h04E2 : o == 2 ? 16'h05DC : 16'h07D0;
  endfunction : lim
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  // The span is sized to cover the longest path, two serial periods included.
  initial begin
    #4000000;
    n_errors++;
    conclude();
  end
  initial begin
    seed = 32'h7173c2a5;
    i_rst = 1'b1;
    {i_wr, i_rd, i_gas_valid, i_transient, pull} = 5'h00;
    i_addr = 4'h0;
    i_wdata = 16'h0000;
    i_gas_raw = 16'h0000;
    i_check = 3'h0;
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (2) @(negedge i_core_clk);
    chk("dac_warm", 16'(o_dac), 16'(WARM_LVL));
    chk("txd_idle", 16'(o_txd), 16'h0001);
    sample(16'($unsigned($random(seed)) % 1000));
    rchk(REG_READING, READ_FAULT, "read_warm");
    rchk(REG_CTRL, 16'(CTRL_RST), "ctrl_rst");
    rchk(REG_SPAN_GAIN, GAIN_ONE, "gain_rst");
    wr(4'hF, 16'hFFFF);
    rchk(4'hF, 16'h0000, "unmapped");
    wr(REG_CTRL, 16'h0020);
    repeat (2) @(negedge i_core_clk);
    chk("dac_bridge", 16'(o_dac), 16'(DAC_ZERO_V));
    wr(REG_CTRL, 16'h0000);
    @(posedge i_core_clk);
    i_check <= 3'h4;
    sample(16'h0BB8);
    chk("dac_warm_fault", 16'(o_dac), 16'h0000);
    @(posedge i_core_clk);
    i_check <= 3'h0;
    repeat (WARM_N) @(posedge i_core_clk);
    rchk(REG_STAT, 16'h0002, "stat_warm");
    rchk(REG_IRQ_STAT, 16'h0003, "irq_stat");
    chk("irq_masked", 16'(o_irq), 16'h0000);
    wr(REG_IRQ_MASK, 16'h001F);
    @(negedge i_core_clk);
    chk("irq_on", 16'(o_irq), 16'h0001);
    wr(REG_IRQ_STAT, 16'h001F);
    @(negedge i_core_clk);
    chk("irq_off", 16'(o_irq), 16'h0000);
    for (k = 0; k < 4; k++) begin
      wr(REG_CTRL, 16'(k << 2));
      v = $unsigned($random(seed)) % 1000;
      sample(16'(v));
      rchk(REG_READING, 16'(v), "read_pass");
      sample(16'h0BB8);
      rchk(REG_READING, lim(k), "read_clamp");
    end
    for (k = 0; k < 3; k++) begin
      @(posedge i_core_clk);
      i_check <= 3'(1 << k);
      sample(16'h0BB8);
      rchk(REG_READING, READ_FAULT, "read_fault");
      chk("dac_fault", 16'(o_dac), 16'h0000);
      rchk(REG_STAT, 16'h0006, "stat_fault");
      @(posedge i_core_clk);
      i_check <= 3'h0;
      sample(16'h0BB8);
      rchk(REG_READING, 16'h07D0, "read_recover");
    end
    rchk(REG_IRQ_STAT, 16'h0002, "irq_fault");
    wr(REG_IRQ_STAT, 16'h001F);
    sample(16'h0190);
    @(posedge i_core_clk);
    i_transient <= 1'b1;
    sample(16'h02BC);
    rchk(REG_READING, 16'h0190, "read_frozen");
    rchk(REG_STAT, 16'h000B, "stat_frozen");
    @(posedge i_core_clk);
    i_transient <= 1'b0;
    repeat (SETTLE_CYCLES + 2) @(posedge i_core_clk);
    sample(16'h02BC);
    rchk(REG_READING, 16'h02BC, "read_thaw");
    rchk(REG_IRQ_STAT, 16'h0004, "irq_freeze");
    wr(REG_IRQ_STAT, 16'h001F);
    for (k = 0; k < 4; k++) begin
      wr(REG_CTRL, k >= 2 ? 16'h0010 : 16'h0000);
      sample(k[0] ? 16'h0000 : 16'h03E8);
      chk("dac_sense", 16'(o_dac), (k == 0 || k == 3) ? 16'h0FFF : 16'h0000);
    end
    rise_wait(v);
    rise_wait(v);
    chk("src_period", 16'(v), 16'(MEAS_N));
    wr(REG_CTRL, 16'h0000);
    sample(16'h02BC);
    // An odd count means a pair is half sent; wait for whole pairs after the sample.
    v = host_count + 4 + host_count[0];
    for (k = 0; k < 3 * MEAS_N && host_count != 8'(v); k++) @(posedge i_core_clk);
    chk("host_word", host_word, 16'h02BC);
    chk("frame_err", 16'(frame_err), 16'h0000);
    z = $unsigned($random(seed)) % 200;
    sample(16'(z));
    press();
    sample(16'(z));
    rchk(REG_READING, 16'h0000, "read_zero");
    rchk(REG_ZERO_OFS, 16'(z), "zero_ofs");
    sample(16'(z + 500));
    press();
    sample(16'(z + 500));
    rchk(REG_READING, 16'h03E8, "read_span");
    rchk(REG_SPAN_GAIN, 16'h0200, "span_gain");
    sample(16'(z + 250));
    rchk(REG_READING, 16'h01F4, "read_cal");
    rchk(REG_IRQ_STAT, 16'h0018, "irq_cal");
    conclude();
  end
endmodule : gso_top_tb
